// >>> logic/triple_buck_control_regs.sv
// Serial-bus register bank with voltage ramp for a triple step-down regulator
// Behaviour
// - Decode registers 0x01, 0x03-0x05, 0x06
// - Bit 7 applies the voltage code
// - Bits 6:0 are channel-two voltage code
// - Code maps linearly, 680 mV plus 10 mV
// - Ramp field sets cycles per step, doubling
// - Command bit 0 low enables channel
// - Command bit 1 high selects light-load mode
// - All control fields reset to zero
// - Control registers writable, flag register read-only
// - Flag bit 7 mirrors over-temperature shutdown
// - Flag bits 6:4 mirror channel overcurrent
// - Flag bit 3 mirrors thermal warning
// - Flag bits 2:0 mirror channel power-good
// - Write is address, register, data, each acknowledged
// - Commit on falling clock of data LSB
// - Ignore bus while all enable pins low
// - Answer only own 7-bit address
`timescale 1ns/1ps
`default_nettype none
module triple_buck_control_regs
  import buck_regs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary target address
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] enable_pin,
  input wire logic switch_clk,
  input wire flags_t flags_in,
  output chan_ctrl_t chan_ctrl,
  output logic code_apply,
  output logic [6:0] voltage_code,
  output logic [10:0] voltage_mv,
  output logic ramp_busy
);
  localparam int SYNC_W = 14;

  // Raw asynchronous pins gathered for the synchroniser
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] s1;
  logic [SYNC_W-1:0] s2;
  logic [SYNC_W-1:0] s3;
  logic [SYNC_W-1:0] filt; // Settled value
  logic [SYNC_W-1:0] filt_q; // Settled value one cycle late
  logic [SYNC_W-1:0] next_filt;

  assign pins_raw = {scl_in, sda_in, enable_pin, switch_clk, flags_in};

  // Three-stage synchroniser per pin; accept a change once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_comb
      begin
        next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
      end
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
          filt[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end
        else
        begin
          s1[gi] <= pins_raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          filt[gi] <= next_filt[gi];
          filt_q[gi] <= filt[gi];
        end
      end
    end
  endgenerate

  // Decoded clean pin views
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic hw_off;
  logic tick;
  flags_t flags_sync;

  assign scl_f = filt[13];
  assign sda_f = filt[12];
  assign scl_rise = scl_f & ~filt_q[13];
  assign scl_fall = ~scl_f & filt_q[13];
  assign bus_start = scl_f & filt_q[13] & ~sda_f & filt_q[12];
  assign bus_stop = scl_f & filt_q[13] & sda_f & ~filt_q[12];
  assign hw_off = (filt[11:9] == 3'b000);
  assign tick = filt[8] & ~filt_q[8];
  assign flags_sync = filt[7:0];

  // Serial target and register state
  serial_state_t state;
  serial_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift; // Receive shifter
  logic [7:0] next_shift;
  logic [7:0] tx; // Transmit shifter
  logic [7:0] next_tx;
  logic [7:0] ptr; // Register pointer
  logic [7:0] next_ptr;
  logic rd_mode; // Address byte asked for a read
  logic next_rd_mode;
  logic [7:0] vcode_reg;
  logic [7:0] next_vcode_reg;
  logic [7:0] cmd_reg [CHANNELS];
  logic [7:0] next_cmd_reg [CHANNELS];

  // Read data for an address; unmapped reads as zero
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    logic [7:0] r;
    r = REG_RESET;
    unique case (a)
      ADDR_VCODE: r = vcode_reg;
      ADDR_CH1: r = cmd_reg[0];
      ADDR_CH2: r = cmd_reg[1];
      ADDR_CH3: r = cmd_reg[2];
      ADDR_FLAGS: r = flags_sync;
      default: r = REG_RESET;
    endcase
    return r;
  endfunction

  // Next state of the serial target and the register file
  always_comb
  begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_tx = tx;
    next_ptr = ptr;
    next_rd_mode = rd_mode;
    next_vcode_reg = vcode_reg;
    next_cmd_reg = cmd_reg;
    if (bus_start)
    begin
      // Start or repeated start always restarts address reception
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
    end
    else if (bus_stop)
    begin
      next_state = ST_IDLE;
    end
    else
    begin
      unique case (state)
        ST_IDLE, ST_IGNORE:
        begin
          next_bit_cnt = 4'h0;
        end
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          // Collect a byte MSB first on rising clock
          if (scl_rise)
          begin
            next_shift = {shift[6:0], sda_f};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == BYTE_BITS)
          begin
            next_bit_cnt = 4'h0;
            if (state == ST_ADDR)
            begin
              next_rd_mode = shift[0];
              // Own address only, never general call or ten-bit prefix
              if (shift[7:1] == DEV_ADDR && shift[7:1] != GENERAL_CALL
                  && shift[7:3] != TEN_BIT_PREFIX && !hw_off)
                next_state = ST_ADDR_ACK;
              else
                next_state = ST_IGNORE;
            end
            else if (state == ST_REG)
            begin
              next_ptr = shift;
              next_state = ST_REG_ACK;
            end
            else
            begin
              // Commit on the falling clock that ends the data LSB
              if (!hw_off)
              begin
                unique case (ptr)
                  ADDR_VCODE: next_vcode_reg = shift;
                  ADDR_CH1: next_cmd_reg[0] = shift;
                  ADDR_CH2: next_cmd_reg[1] = shift;
                  ADDR_CH3: next_cmd_reg[2] = shift;
                  default: next_vcode_reg = vcode_reg;
                endcase
              end
              next_ptr = ptr + 8'h01;
              next_state = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rd_mode)
            begin
              next_tx = read_mux(ptr);
              next_state = ST_RDATA;
            end
            else
              next_state = ST_REG;
          end
        end
        ST_REG_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
            next_state = ST_WDATA;
        end
        ST_RDATA:
        begin
          // Shift out on falling clock, count on rising clock
          if (scl_rise)
            next_bit_cnt = bit_cnt + 4'h1;
          else if (scl_fall)
          begin
            if (bit_cnt == BYTE_BITS)
            begin
              next_bit_cnt = 4'h0;
              next_ptr = ptr + 8'h01;
              next_state = ST_RDATA_ACK;
            end
            else
              next_tx = {tx[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK:
        begin
          // Controller not-acknowledge ends the read
          if (scl_rise && sda_f)
            next_state = ST_IGNORE;
          else if (scl_fall)
          begin
            next_tx = read_mux(ptr);
            next_state = ST_RDATA;
          end
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Register the serial target and register file
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= REG_RESET;
      tx <= REG_RESET;
      ptr <= REG_RESET;
      rd_mode <= 1'b0;
      vcode_reg <= REG_RESET;
      for (int i = 0; i < CHANNELS; i++)
        cmd_reg[i] <= REG_RESET;
    end
    else
    begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      tx <= next_tx;
      ptr <= next_ptr;
      rd_mode <= next_rd_mode;
      vcode_reg <= next_vcode_reg;
      cmd_reg <= next_cmd_reg;
    end
  end

  // Open-drain data: only ever pull low
  assign sda_out = 1'b0;
  always_comb
  begin
    unique case (state)
      ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: sda_oe = 1'b1;
      ST_RDATA: sda_oe = ~tx[7];
      default: sda_oe = 1'b0;
    endcase
  end

  // Channel controls straight from the command registers
  generate
    for (gi = 0; gi < CHANNELS; gi++)
    begin : g_chan
      assign chan_ctrl.ch_off[gi] = cmd_reg[gi][OFF_BIT];
      assign chan_ctrl.light_load[gi] = cmd_reg[gi][LIGHT_LOAD_BIT];
    end
  endgenerate

  // Ramp state
  logic [6:0] cur_code;
  logic [6:0] next_cur_code;
  logic [RAMP_CNT_W-1:0] step_cnt;
  logic [RAMP_CNT_W-1:0] next_step_cnt;
  logic [10:0] next_voltage_mv;
  logic [2:0] ramp_rate;
  logic [6:0] target;
  logic [RAMP_CNT_W-1:0] step_len;

  assign ramp_rate = cmd_reg[1][RAMP_MSB:RAMP_LSB];
  assign target = vcode_reg[CODE_W-1:0];
  assign step_len = RAMP_CNT_W'(1) << ramp_rate;

  // Step the applied code one unit per selected number of switching cycles
  always_comb
  begin
    next_cur_code = cur_code;
    next_step_cnt = step_cnt;
    if (!vcode_reg[APPLY_BIT] || cur_code == target)
      next_step_cnt = '0;
    else if (tick)
    begin
      if (step_cnt + RAMP_CNT_W'(1) >= step_len)
      begin
        next_step_cnt = '0;
        next_cur_code = (cur_code < target) ? cur_code + 7'h01 : cur_code - 7'h01;
      end
      else
        next_step_cnt = step_cnt + RAMP_CNT_W'(1);
    end
    next_voltage_mv = MV_BASE + MV_STEP * MV_W'(next_cur_code);
  end

  // Register ramp state and its data outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_code <= '0;
      step_cnt <= '0;
      voltage_mv <= MV_BASE;
      code_apply <= 1'b0;
      ramp_busy <= 1'b0;
    end
    else
    begin
      cur_code <= next_cur_code;
      step_cnt <= next_step_cnt;
      voltage_mv <= next_voltage_mv;
      code_apply <= vcode_reg[APPLY_BIT];
      ramp_busy <= vcode_reg[APPLY_BIT] && (next_cur_code != target);
    end
  end

  assign voltage_code = cur_code;
endmodule
`default_nettype wire

// >>> common/buck_regs_pkg.sv
// Constants, field layouts and types for the regulator control register bank
package buck_regs_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_VCODE = 8'h01;
  localparam logic [7:0] ADDR_CH1 = 8'h03;
  localparam logic [7:0] ADDR_CH2 = 8'h04;
  localparam logic [7:0] ADDR_CH3 = 8'h05;
  localparam logic [7:0] ADDR_FLAGS = 8'h06;
  // Reset value of every control and status register
  localparam logic [7:0] REG_RESET = 8'h00;
  // Field positions
  localparam int APPLY_BIT = 7;
  localparam int OFF_BIT = 0;
  localparam int LIGHT_LOAD_BIT = 1;
  localparam int RAMP_LSB = 4;
  localparam int RAMP_MSB = 6;
  localparam int CODE_W = 7;
  localparam int CHANNELS = 3;
  // Output voltage mapping in millivolts
  localparam int MV_W = 11;
  localparam logic [10:0] MV_BASE = 11'h2A8;
  localparam logic [10:0] MV_STEP = 11'h00A;
  // Serial protocol constants
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] GENERAL_CALL = 7'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  // Ramp counter width, enough for 128 cycles per step
  localparam int RAMP_CNT_W = 8;
  // Status inputs as laid out in the flag register
  typedef struct packed {
    logic over_temp;
    logic [2:0] overcurrent;
    logic thermal_warning;
    logic [2:0] regulation_ok;
  } flags_t;
  // Per-channel control outputs, index 0 is channel one
  typedef struct packed {
    logic [2:0] ch_off;
    logic [2:0] light_load;
  } chan_ctrl_t;
  // Serial target states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8,
    ST_IGNORE = 4'h9
  } serial_state_t;
endpackage

// >>> tb/buck_regs_monitor.sv
// Port assertions for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
module buck_regs_monitor
  import buck_regs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic [2:0] enable_pin,
  input wire chan_ctrl_t chan_ctrl,
  input wire logic code_apply,
  input wire logic [6:0] voltage_code,
  input wire logic [10:0] voltage_mv,
  input wire logic ramp_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Acknowledge only moves while the bus clock is low
  AST_ACK_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("ack moved in high phase");
  // Commit follows a bus clock fall
  AST_COMMIT: assert property ($changed(chan_ctrl) |-> !scl_in)
    else $error("commit in high phase");
  // Hardware shutdown freezes the controls
  AST_HW_OFF: assert property ((enable_pin == 3'h0)[*8] |=> $stable(chan_ctrl))
    else $error("write taken in shutdown");
  // Millivolt output follows the code
  AST_MV: assert property ($stable(voltage_code) |->
    voltage_mv == MV_BASE + MV_STEP * voltage_code)
    else $error("millivolt map wrong");
  // Ramp moves one code at a time
  AST_STEP: assert property ($changed(voltage_code) |-> voltage_code ==
    $past(voltage_code) + 7'h01 || voltage_code == $past(voltage_code) - 7'h01)
    else $error("code jumped");
  // Without apply the code holds
  AST_HOLD: assert property (!code_apply |-> $stable(voltage_code))
    else $error("code moved without apply");
  // Steps are paced by switching cycles
  AST_PACE: assert property ($changed(voltage_code) |=> $stable(voltage_code)[*8])
    else $error("steps too close");
  // Busy only starts under apply
  AST_BUSY: assert property ($rose(ramp_busy) |-> code_apply)
    else $error("busy without apply");
  cover property ($rose(ramp_busy));
  cover property ($rose(sda_oe));
  cover property ($changed(chan_ctrl));
endmodule
bind triple_buck_control_regs buck_regs_monitor mon (.clk(clk), .reset_n(reset_n),
  .scl_in(scl_in), .sda_oe(sda_oe), .enable_pin(enable_pin), .chan_ctrl(chan_ctrl),
  .code_apply(code_apply), .voltage_code(voltage_code), .voltage_mv(voltage_mv),
  .ramp_busy(ramp_busy));
`default_nettype wire

// >>> tb/bus_host.sv
// Two-wire bus controller model, open drain
`timescale 1ns/1ps
`default_nettype none
module bus_host(
  input wire logic clk,
  input wire logic line,
  output logic scl,
  output logic sda
);
  initial scl = 1'b1;
  initial sda = 1'b1;
  // Wait clocks, then step off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Start or repeated start
  task automatic start;
    wt(3);
    sda = 1'b1;
    wt(9);
    scl = 1'b1;
    wt(9);
    sda = 1'b0;
    wt(9);
    scl = 1'b0;
  endtask
  // Stop, bus left idle high
  task automatic stop;
    wt(3);
    sda = 1'b0;
    wt(9);
    scl = 1'b1;
    wt(9);
    sda = 1'b1;
    wt(9);
  endtask
  // One bit, line sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    wt(3);
    sda = b;
    wt(9);
    scl = 1'b1;
    wt(9);
    r = line;
    scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import buck_regs_pkg::*;
  localparam logic [6:0] DEV = 7'h2A; // Arbitrary target address
  localparam logic [7:0] ADS [5] = '{ADDR_VCODE, ADDR_CH1, ADDR_CH2, ADDR_CH3, ADDR_FLAGS};
  localparam logic [6:0] BAD [3] = '{7'h2B, GENERAL_CALL, 7'h78};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic switch_clk = 1'b0;
  logic [2:0] enable_pin = 3'h7;
  flags_t flags_in = 8'h00;
  logic scl, hsda, sda_out, sda_oe, code_apply, ramp_busy;
  chan_ctrl_t chan_ctrl;
  logic [6:0] voltage_code;
  logic [10:0] voltage_mv;
  int bad_count = 0;
  int tests_run = 0;
  wire logic line = hsda & ~sda_oe; // Pulled-up data wire
  bus_host h (.clk(clk), .line(line), .scl(scl), .sda(hsda));
  triple_buck_control_regs #(.DEV_ADDR(DEV)) uut (.clk(clk), .reset_n(reset_n),
    .scl_in(scl), .sda_in(line), .sda_out(sda_out), .sda_oe(sda_oe),
    .enable_pin(enable_pin), .switch_clk(switch_clk), .flags_in(flags_in),
    .chan_ctrl(chan_ctrl), .code_apply(code_apply), .voltage_code(voltage_code),
    .voltage_mv(voltage_mv), .ramp_busy(ramp_busy));
  initial forever #20 clk = ~clk;
  // Switching cycle every 24 clocks
  initial forever
  begin
    repeat (12) @(posedge clk);
    #1 switch_clk = ~switch_clk;
  end
  task automatic xb(input logic [7:0] d, input logic l, output logic [7:0] q,
    output logic r);
    for (int i = 7; i >= 0; i--)
      h.bitx(d[i], q[i]);
    h.bitx(l, r);
  endtask
  task automatic wreg(input logic [7:0] a, d, input logic [6:0] dv, output logic ok);
    logic [7:0] q;
    logic r;
    h.start();
    xb({dv, 1'b0}, 1'b1, q, r);
    ok = ~r;
    xb(a, 1'b1, q, r);
    xb(d, 1'b1, q, r);
    h.stop();
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic r;
    h.start();
    xb({DEV, 1'b0}, 1'b1, q, r);
    xb(a, 1'b1, q, r);
    h.start();
    xb({DEV, 1'b1}, 1'b1, q, r);
    xb(8'hFF, 1'b1, d, r);
    h.stop();
  endtask
  task automatic cv(input string n, input logic [10:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic t_reset;
    logic [7:0] d;
    foreach (ADS[i])
    begin
      rreg(ADS[i], d);
      cv("reset reg", 8'h00, d);
    end
    cv("reset mv", 11'h2A8, voltage_mv);
    cv("sda out", 1'b0, sda_out);
    $display("t_reset done");
  endtask
  task automatic t_cmd;
    logic ok;
    logic [7:0] d;
    wreg(ADDR_CH1, 8'hFE, DEV, ok);
    cv("ack", 1'b1, ok);
    wreg(ADDR_CH2, 8'hAA, DEV, ok);
    wreg(ADDR_CH3, 8'h01, DEV, ok);
    wreg(8'h02, 8'h55, DEV, ok);
    cv("ctrl", 6'h23, chan_ctrl);
    rreg(ADDR_CH1, d);
    cv("ch1", 8'hFE, d);
    rreg(ADDR_CH2, d);
    cv("ch2", 8'hAA, d);
    rreg(8'h02, d);
    cv("gap", 8'h00, d);
    $display("t_cmd done");
  endtask
  task automatic t_refuse;
    logic ok;
    logic [7:0] d;
    foreach (BAD[i])
    begin
      wreg(ADDR_CH1, 8'h55, BAD[i], ok);
      cv("nack", 1'b0, ok);
    end
    enable_pin = 3'h0;
    wreg(ADDR_CH1, 8'h55, DEV, ok);
    cv("off nack", 1'b0, ok);
    enable_pin = 3'h4;
    wreg(ADDR_CH3, 8'h03, DEV, ok);
    cv("one pin ack", 1'b1, ok);
    cv("ctrl ch3", 6'h27, chan_ctrl);
    enable_pin = 3'h7;
    rreg(ADDR_CH1, d);
    cv("ch1 kept", 8'hFE, d);
    $display("t_refuse done");
  endtask
  task automatic t_flags;
    logic ok;
    logic [7:0] d;
    flags_in = 8'hA5;
    rreg(ADDR_FLAGS, d);
    cv("flags", 8'hA5, d);
    wreg(ADDR_FLAGS, 8'h00, DEV, ok);
    rreg(ADDR_FLAGS, d);
    cv("flags ro", 8'hA5, d);
    flags_in = 8'h5A;
    rreg(ADDR_FLAGS, d);
    cv("flags", 8'h5A, d);
    $display("t_flags done");
  endtask
  task automatic t_ramp;
    logic ok;
    int n;
    logic [6:0] c;
    wreg(ADDR_CH2, 8'h30, DEV, ok);
    wreg(ADDR_VCODE, 8'h85, DEV, ok);
    repeat (3000) if (voltage_code !== 7'h05) h.wt(1);
    h.wt(2);
    cv("code", 7'h05, voltage_code);
    cv("mv", 11'h2DA, voltage_mv);
    wreg(ADDR_VCODE, 8'h82, DEV, ok);
    cv("busy", 1'b1, ramp_busy);
    c = voltage_code;
    repeat (3000) if (voltage_code === c) h.wt(1);
    c = voltage_code;
    n = 0;
    while (voltage_code === c && n < 3000)
    begin
      h.wt(1);
      n++;
    end
    cv("step gap", 11'h0C0, n[10:0]);
    repeat (3000) if (voltage_code !== 7'h02) h.wt(1);
    wreg(ADDR_VCODE, 8'h10, DEV, ok);
    cv("apply off", 1'b0, code_apply);
    h.wt(600);
    cv("held", 7'h02, voltage_code);
    wreg(ADDR_CH2, 8'h00, DEV, ok);
    wreg(ADDR_VCODE, 8'hFF, DEV, ok);
    repeat (5000) if (voltage_code !== 7'h7F) h.wt(1);
    h.wt(2);
    cv("top mv", 11'h79E, voltage_mv);
    cv("busy", 1'b0, ramp_busy);
    cv("apply on", 1'b1, code_apply);
    $display("t_ramp done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    h.wt(10);
    t_reset();
    t_cmd();
    t_refuse();
    t_flags();
    t_ramp();
    complete_run();
  end
  // Watchdog against a hung bus
  initial
  begin
    repeat (80000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
